/* File: rtl/tlal_pkg.sv */
package tlal_pkg;
  // timing: printed times in microseconds, cycle counts derived from the clock rate
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned CONV_TIME_US = 31250;
  localparam int unsigned CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_MIN_US = 25000;
  localparam int unsigned TIMEOUT_MAX_US = 35000;
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MIN_US * CLK_MHZ;
  localparam int unsigned RATE_W = 4;

  // register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_RATE = 8'h04;
  localparam logic [7:0] ADR_LOC_UPPER = 8'h08;
  localparam logic [7:0] ADR_REM_UPPER = 8'h0C;
  localparam logic [7:0] ADR_REM_LOWER = 8'h10;
  localparam logic [7:0] ADR_REM_CRIT = 8'h14;
  localparam logic [7:0] ADR_HYST = 8'h18;
  localparam logic [7:0] ADR_REM_OFFSET = 8'h1C;
  localparam logic [7:0] ADR_LOC_READ = 8'h20;
  localparam logic [7:0] ADR_REM_READ = 8'h24;
  localparam logic [7:0] ADR_STATUS = 8'h28;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h2C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h30;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] LOC_UPPER_RST = 8'h46;
  localparam logic [15:0] REM_UPPER_RST = 16'h4600;
  localparam logic [15:0] REM_LOWER_RST = 16'h0000;
  localparam logic [15:0] REM_CRIT_RST = 16'h6E00;
  localparam logic [7:0] HYST_RST = 8'h0A;
  localparam logic [15:0] REM_OFFSET_RST = 16'h0000;

  // remote word: 11 significant bits left justified, low 5 bits zero
  localparam int unsigned REM_PAD = 5;
  localparam logic [15:0] REM_KEEP = 16'hFFE0;
  // status bits that may drive the alert pin (busy and open excluded)
  localparam logic [5:0] STATUS_ALERT_BITS = 6'h0F;
  // interrupt bit positions
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_CONV = 0;
  localparam int unsigned IRQ_ALERT = 1;
  localparam int unsigned IRQ_TIMEOUT = 2;

  typedef struct packed {
    logic comp_mode;       // alert follows live comparison
    logic alert_mask;      // one blocks the alert pin
    logic pwm_off_standby; // stop pwm in standby
    logic standby;         // halt conversions
  } tlal_ctrl_t;

  typedef struct packed {
    logic busy;
    logic diode_open;
    logic remote_crit;
    logic remote_high;
    logic remote_low;
    logic local_high;
  } tlal_status_t;
endpackage

/* File: rtl/tlal_sync.sv */
`timescale 1ns/1ns
// two-stage synchroniser for pin inputs
module tlal_sync #(
  parameter int unsigned W = 2
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg; // first stage, read only by second stage
  logic [W-1:0] q_reg;

  // lines idle high, so reset to ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '1;
      q_reg <= '1;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule

/* File: rtl/tlal_limit_cmp.sv */
`timescale 1ns/1ns
// signed limit comparator with hysteresis band
module tlal_limit_cmp #(
  parameter int unsigned W = 8,
  parameter bit UPPER = 1'b1
)(
  input wire logic [W-1:0] value_i,
  input wire logic [W-1:0] limit_i,
  input wire logic [W-1:0] hyst_i,
  output logic trip_o,
  output logic clear_o
);
  logic signed [W+1:0] val_s; // widened to keep band math from wrapping
  logic signed [W+1:0] lim_s;
  logic signed [W+1:0] band_s;

  // trip outside the limit, clear only once back past the band
  always_comb begin
    val_s = signed'({{2{value_i[W-1]}}, value_i});
    lim_s = signed'({{2{limit_i[W-1]}}, limit_i});
    band_s = UPPER ? (lim_s - signed'({2'b00, hyst_i})) : (lim_s + signed'({2'b00, hyst_i}));
    trip_o = UPPER ? (val_s > lim_s) : (val_s < lim_s);
    clear_o = UPPER ? (val_s <= band_s) : (val_s >= band_s);
  end
endmodule

/* File: rtl/tlal_top.sv */
`timescale 1ns/1ns
// Functional notes
// - compare local and remote readings against limits
// - set alert status bit after out-of-limit reading
// - unmasked status bits pull alert low
// - mask bit zero enables, one suppresses alert
// - critical output follows remote over critical, unlatched
// - hysteresis taken from hysteresis register
// - standby bit stops continuous conversions
// - standby pwm runs or stops per config
// - each conversion takes 31.25 ms
// - slower rate adds idle, conversion unchanged
// - 8-bit local, left-justified 11-bit remote words
// - signed offset added to remote reading
// - serial line low timeout resets, releases pins
// - serial timeout between 25 and 35 ms
// - comparator mode releases alert when condition clears
// - status clears on read, resets if persisting
module tlal_top #(
  parameter int unsigned CONV_CYCLES = tlal_pkg::CONV_CYCLES,
  parameter int unsigned TIMEOUT_CYCLES = tlal_pkg::TIMEOUT_CYCLES,
  parameter int unsigned RATE_W = tlal_pkg::RATE_W
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] local_sample_i,
  input wire logic [10:0] remote_sample_i,
  input wire logic diode_open_i,
  output logic conv_start_o,
  input wire logic pwm_low_i,
  output logic pwm_oe_o,
  output logic alert_oe_o,
  output logic tcrit_oe_o,
  input wire logic smb_scl_i,
  input wire logic smb_sda_i,
  input wire logic smb_sda_drive_i,
  output logic smb_sda_o,
  output logic smb_sda_oe_o,
  output logic smb_scl_oe_o,
  output logic smb_if_reset_o,
  output logic irq_o
);
  import tlal_pkg::*;

  localparam int unsigned TW = $clog2(CONV_CYCLES + 1);
  localparam int unsigned OW = $clog2(TIMEOUT_CYCLES + 1);

  typedef enum logic [1:0] {SEQ_STANDBY, SEQ_CONVERT, SEQ_PAUSE} tlal_seq_t;

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] tlal_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------- bus state
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic acc; // access taken this cycle
  logic wr; // write taken this cycle
  logic st_read; // status register being read

  // ---------------- configuration state
  tlal_ctrl_t ctrl_reg, ctrl_next;
  logic [RATE_W-1:0] rate_reg, rate_next; // idle conversion periods between conversions
  logic [7:0] loc_upper_reg, loc_upper_next; // local_upper_limit
  logic [15:0] rem_upper_reg, rem_upper_next; // remote_upper_limit
  logic [15:0] rem_lower_reg, rem_lower_next; // remote_lower_limit
  logic [15:0] rem_crit_reg, rem_crit_next; // remote_critical_limit
  logic [7:0] hyst_reg, hyst_next; // hysteresis_value, whole degrees
  logic [15:0] offset_reg, offset_next; // remote_offset_upper_byte : remote_offset_lower_byte
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;

  // ---------------- sequencer state
  tlal_seq_t seq_reg, seq_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic [RATE_W-1:0] pause_reg, pause_next;
  logic start_reg, start_next;
  logic done; // conversion completes at this edge

  // ---------------- readings and alerts
  logic [7:0] local_reading_reg, local_reading_next;
  logic [15:0] remote_reading_reg, remote_reading_next;
  logic [15:0] remote_corr; // offset-corrected remote word
  logic [15:0] rem_hyst; // hysteresis scaled to the remote word
  tlal_status_t status_reg, status_next;
  logic [3:0] act_reg, act_next; // comparator-mode active flags
  logic alert_reg, alert_next;
  logic tcrit_reg, tcrit_next;
  logic pwm_reg, pwm_next;
  logic [3:0] trip, clr;
  logic [IRQ_W-1:0] irq_st_reg, irq_st_next;
  logic irq_reg, irq_next;

  // ---------------- serial timeout
  logic [1:0] pin_s; // {scl, sda} synchronised
  logic [OW-1:0] to_cnt_reg, to_cnt_next;
  logic hold_reg, hold_next;
  logic to_pulse_reg, to_pulse_next;
  logic sda_oe_reg, sda_oe_next;

  tlal_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({smb_scl_i, smb_sda_i}),
    .q_o(pin_s)
  );

  // remote word: sample left justified, plus signed offset, low 5 bits cleared
  assign remote_corr = ({remote_sample_i, {REM_PAD{1'b0}}} + offset_reg) & REM_KEEP;
  assign rem_hyst = {hyst_reg, 8'h00};

  // limit comparators on new samples
  tlal_limit_cmp #(.W(8), .UPPER(1'b1)) u_loc_hi (
    .value_i(local_sample_i), .limit_i(loc_upper_reg), .hyst_i(hyst_reg),
    .trip_o(trip[0]), .clear_o(clr[0])
  );
  tlal_limit_cmp #(.W(16), .UPPER(1'b0)) u_rem_lo (
    .value_i(remote_corr), .limit_i(rem_lower_reg), .hyst_i(rem_hyst),
    .trip_o(trip[1]), .clear_o(clr[1])
  );
  tlal_limit_cmp #(.W(16), .UPPER(1'b1)) u_rem_hi (
    .value_i(remote_corr), .limit_i(rem_upper_reg), .hyst_i(rem_hyst),
    .trip_o(trip[2]), .clear_o(clr[2])
  );
  tlal_limit_cmp #(.W(16), .UPPER(1'b1)) u_rem_crit (
    .value_i(remote_corr), .limit_i(rem_crit_reg), .hyst_i(rem_hyst),
    .trip_o(trip[3]), .clear_o(clr[3])
  );

  // bus: ack one cycle after the strobe, dropped the cycle after
  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    acc = ack_next;
    wr = acc & wb_we_i;
    st_read = acc & ~wb_we_i & (wb_adr_i == ADR_STATUS);
    dat_next = dat_reg;
    if (acc & ~wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CTRL: dat_next = {28'h000_0000, ctrl_reg};
        ADR_RATE: dat_next = {{(32-RATE_W){1'b0}}, rate_reg};
        ADR_LOC_UPPER: dat_next = {24'h00_0000, loc_upper_reg};
        ADR_REM_UPPER: dat_next = {16'h0000, rem_upper_reg};
        ADR_REM_LOWER: dat_next = {16'h0000, rem_lower_reg};
        ADR_REM_CRIT: dat_next = {16'h0000, rem_crit_reg};
        ADR_HYST: dat_next = {24'h00_0000, hyst_reg};
        ADR_REM_OFFSET: dat_next = {16'h0000, offset_reg};
        ADR_LOC_READ: dat_next = {24'h00_0000, local_reading_reg};
        ADR_REM_READ: dat_next = {16'h0000, remote_reading_reg};
        ADR_STATUS: dat_next = {26'h000_0000, status_reg};
        ADR_IRQ_STATUS: dat_next = {{(32-IRQ_W){1'b0}}, irq_st_reg};
        ADR_IRQ_MASK: dat_next = {{(32-IRQ_W){1'b0}}, irq_mask_reg};
        default: dat_next = 32'h0000_0000; // unmapped reads zero, still acked
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // configuration writes; a status read in interrupt mode masks further alerts
  always_comb begin
    ctrl_next = ctrl_reg;
    rate_next = rate_reg;
    loc_upper_next = loc_upper_reg;
    rem_upper_next = rem_upper_reg;
    rem_lower_next = rem_lower_reg;
    rem_crit_next = rem_crit_reg;
    hyst_next = hyst_reg;
    offset_next = offset_reg;
    irq_mask_next = irq_mask_reg;
    if (wr) begin
      unique case (wb_adr_i)
        ADR_CTRL: ctrl_next = 4'(tlal_merge({28'h000_0000, ctrl_reg}, wb_dat_i, wb_sel_i));
        ADR_RATE: rate_next = RATE_W'(tlal_merge({{(32-RATE_W){1'b0}}, rate_reg}, wb_dat_i, wb_sel_i));
        ADR_LOC_UPPER: loc_upper_next = 8'(tlal_merge({24'h00_0000, loc_upper_reg}, wb_dat_i, wb_sel_i));
        ADR_REM_UPPER: rem_upper_next = 16'(tlal_merge({16'h0000, rem_upper_reg}, wb_dat_i, wb_sel_i)) & REM_KEEP;
        ADR_REM_LOWER: rem_lower_next = 16'(tlal_merge({16'h0000, rem_lower_reg}, wb_dat_i, wb_sel_i)) & REM_KEEP;
        ADR_REM_CRIT: rem_crit_next = 16'(tlal_merge({16'h0000, rem_crit_reg}, wb_dat_i, wb_sel_i)) & REM_KEEP;
        ADR_HYST: hyst_next = 8'(tlal_merge({24'h00_0000, hyst_reg}, wb_dat_i, wb_sel_i));
        ADR_REM_OFFSET: offset_next = 16'(tlal_merge({16'h0000, offset_reg}, wb_dat_i, wb_sel_i)) & REM_KEEP;
        ADR_IRQ_MASK: irq_mask_next = IRQ_W'(tlal_merge({{(32-IRQ_W){1'b0}}, irq_mask_reg}, wb_dat_i, wb_sel_i));
        default: ; // read-only, unmapped or interrupt status (write one to clear, below): ignored here
      endcase
    end
    if (st_read & ~ctrl_reg.comp_mode & (|(status_reg & STATUS_ALERT_BITS))) begin
      ctrl_next.alert_mask = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      rate_reg <= '0;
      loc_upper_reg <= LOC_UPPER_RST;
      rem_upper_reg <= REM_UPPER_RST;
      rem_lower_reg <= REM_LOWER_RST;
      rem_crit_reg <= REM_CRIT_RST;
      hyst_reg <= HYST_RST;
      offset_reg <= REM_OFFSET_RST;
      irq_mask_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      rate_reg <= rate_next;
      loc_upper_reg <= loc_upper_next;
      rem_upper_reg <= rem_upper_next;
      rem_lower_reg <= rem_lower_next;
      rem_crit_reg <= rem_crit_next;
      hyst_reg <= hyst_next;
      offset_reg <= offset_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // conversion sequencer; standby lets a running conversion finish so readings stay whole
  always_comb begin
    seq_next = seq_reg;
    timer_next = timer_reg;
    pause_next = pause_reg;
    start_next = 1'b0;
    done = 1'b0;
    unique case (seq_reg)
      SEQ_STANDBY: begin
        if (!ctrl_reg.standby) begin
          seq_next = SEQ_CONVERT;
          timer_next = '0;
          start_next = 1'b1;
        end
      end
      SEQ_CONVERT: begin
        if (timer_reg == TW'(CONV_CYCLES - 1)) begin
          done = 1'b1;
          timer_next = '0;
          pause_next = rate_reg;
          if (ctrl_reg.standby) begin
            seq_next = SEQ_STANDBY;
          end else if (rate_reg != '0) begin
            seq_next = SEQ_PAUSE;
          end else begin
            start_next = 1'b1;
          end
        end else begin
          timer_next = timer_reg + 1'b1;
        end
      end
      SEQ_PAUSE: begin
        // idle periods are whole conversion lengths
        if (ctrl_reg.standby) begin
          seq_next = SEQ_STANDBY;
        end else if (timer_reg == TW'(CONV_CYCLES - 1)) begin
          timer_next = '0;
          pause_next = pause_reg - 1'b1;
          if (pause_reg <= RATE_W'(1)) begin
            seq_next = SEQ_CONVERT;
            start_next = 1'b1;
          end
        end else begin
          timer_next = timer_reg + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_reg <= SEQ_STANDBY;
      timer_reg <= '0;
      pause_reg <= '0;
      start_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      timer_reg <= timer_next;
      pause_reg <= pause_next;
      start_reg <= start_next;
    end
  end

  // readings, flag sets and critical pin taken at the conversion-done edge; alert and pwm pins update every cycle
  always_comb begin
    local_reading_next = local_reading_reg;
    remote_reading_next = remote_reading_reg;
    status_next = status_reg;
    act_next = act_reg;
    tcrit_next = tcrit_reg;
    if (st_read) begin
      status_next = '0;
    end
    if (done) begin
      local_reading_next = local_sample_i;
      remote_reading_next = remote_corr;
      // sets applied after the read clear so an event never gets lost
      status_next.local_high = status_next.local_high | trip[0];
      status_next.remote_low = status_next.remote_low | trip[1];
      status_next.remote_high = status_next.remote_high | trip[2];
      status_next.remote_crit = status_next.remote_crit | trip[3];
      status_next.diode_open = status_next.diode_open | diode_open_i;
      act_next = trip | (act_reg & ~clr);
      tcrit_next = trip[3];
    end
    status_next.busy = (seq_next == SEQ_CONVERT);
    // pin evaluated from the same next flags, so both move on one edge
    if (ctrl_next.alert_mask) begin
      alert_next = 1'b0;
    end else if (ctrl_reg.comp_mode) begin
      alert_next = |act_next;
    end else begin
      alert_next = |(status_next & STATUS_ALERT_BITS);
    end
    pwm_next = pwm_low_i & ~(ctrl_reg.standby & ctrl_reg.pwm_off_standby);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      local_reading_reg <= 8'h00;
      remote_reading_reg <= 16'h0000;
      status_reg <= '0;
      act_reg <= 4'h0;
      alert_reg <= 1'b0;
      tcrit_reg <= 1'b0;
      pwm_reg <= 1'b0;
    end else begin
      local_reading_reg <= local_reading_next;
      remote_reading_reg <= remote_reading_next;
      status_reg <= status_next;
      act_reg <= act_next;
      alert_reg <= alert_next;
      tcrit_reg <= tcrit_next;
      pwm_reg <= pwm_next;
    end
  end

  // serial low timeout: hold pins released until both lines are high again
  always_comb begin
    to_cnt_next = to_cnt_reg;
    hold_next = hold_reg;
    to_pulse_next = 1'b0;
    if (pin_s != 2'b11) begin
      if (to_cnt_reg == OW'(TIMEOUT_CYCLES - 1)) begin
        to_pulse_next = ~hold_reg;
        hold_next = 1'b1;
      end else begin
        to_cnt_next = to_cnt_reg + 1'b1;
      end
    end else begin
      to_cnt_next = '0;
      hold_next = 1'b0;
    end
    sda_oe_next = smb_sda_drive_i & ~hold_next;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_cnt_reg <= '0;
      hold_reg <= 1'b0;
      to_pulse_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      to_cnt_reg <= to_cnt_next;
      hold_reg <= hold_next;
      to_pulse_reg <= to_pulse_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // interrupt: sticky events, write one to clear, set wins
  always_comb begin
    irq_st_next = irq_st_reg;
    if (wr && wb_adr_i == ADR_IRQ_STATUS && wb_sel_i[0]) begin
      irq_st_next = irq_st_reg & ~wb_dat_i[IRQ_W-1:0];
    end
    irq_st_next[IRQ_CONV] = irq_st_next[IRQ_CONV] | done;
    irq_st_next[IRQ_ALERT] = irq_st_next[IRQ_ALERT] | (alert_next & ~alert_reg);
    irq_st_next[IRQ_TIMEOUT] = irq_st_next[IRQ_TIMEOUT] | to_pulse_next;
    irq_next = |(irq_st_next & irq_mask_next);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_st_reg <= irq_st_next;
      irq_reg <= irq_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign conv_start_o = start_reg;
  assign pwm_oe_o = pwm_reg;
  assign alert_oe_o = alert_reg;
  assign tcrit_oe_o = tcrit_reg;
  assign smb_sda_o = 1'b0; // open drain: only ever drives low
  assign smb_sda_oe_o = sda_oe_reg;
  assign smb_scl_oe_o = 1'b0; // clock never driven, no stretching
  assign smb_if_reset_o = to_pulse_reg;
  assign irq_o = irq_reg;
endmodule

/* File: verif/tlal_props.sv */
`timescale 1ns/1ns
// port watcher for the limit alert block
module tlal_props
  import tlal_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = 50,
  parameter int unsigned TIMEOUT_CYCLES = 40
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic conv_start_o,
  input wire logic pwm_oe_o,
  input wire logic alert_oe_o,
  input wire logic tcrit_oe_o,
  input wire logic smb_scl_i,
  input wire logic smb_sda_i,
  input wire logic smb_sda_o,
  input wire logic smb_sda_oe_o,
  input wire logic smb_scl_oe_o,
  input wire logic smb_if_reset_o
);
  logic [15:0] cnt_reg, cnt_next; // cycles since last conversion start
  logic [15:0] low_reg, low_next; // cycles with a serial line low
  logic [3:0] ctl_reg, ctl_next; // shadow of the control bits
  logic at_end; // a conversion result may land now
  // shadow state next values
  always_comb begin
    cnt_next = conv_start_o ? 16'h0001 : cnt_reg + {15'h0000, cnt_reg != 16'hFFFF};
    low_next = (smb_scl_i && smb_sda_i) ? 16'h0000 : low_reg + 16'h0001;
    ctl_next = ctl_reg;
    if (wb_ack_o && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
      ctl_next = wb_dat_i[3:0];
    end
    // interrupt-mode status read masks the pin, the design does it too
    if (wb_ack_o && !wb_we_i && wb_adr_i == ADR_STATUS && !ctl_reg[3] && |wb_dat_o[3:0]) begin
      ctl_next[2] = 1'b1;
    end
  end
  // shadow state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
      low_reg <= 16'h0000;
      ctl_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
      low_reg <= low_next;
      ctl_reg <= ctl_next;
    end
  end
  // one cycle of slack either side of the conversion end
  assign at_end = cnt_reg >= 16'(CONV_CYCLES - 1) && cnt_reg <= 16'(CONV_CYCLES + 1);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_conv_quiet;
    !conv_start_o [*8];
  endsequence
  sequence s_bus_cause;
    wb_ack_o || $past(wb_ack_o);
  endsequence
  a_conv_gap: assert property (conv_start_o |=> s_conv_quiet)
    else $error("conversion restarted too soon");
  a_tcrit_timing: assert property ($changed(tcrit_oe_o) |-> at_end)
    else $error("critical pin moved outside a conversion end");
  a_alert_timing: assert property ($changed(alert_oe_o) |-> at_end or s_bus_cause)
    else $error("alert pin moved without cause");
  a_alert_masked: assert property (ctl_next[2] |-> !alert_oe_o)
    else $error("alert pulled while masked");
  a_standby_halt: assert property (ctl_reg[0] && cnt_reg > 16'(CONV_CYCLES + 1) |-> !conv_start_o)
    else $error("conversion started in standby");
  a_standby_pwm: assert property (ctl_reg[0] && ctl_reg[1] && cnt_reg > 16'(CONV_CYCLES + 2) |-> !pwm_oe_o)
    else $error("pwm driven in standby");
  a_timeout_span: assert property (smb_if_reset_o |->
    low_reg >= 16'(TIMEOUT_CYCLES - 1) && low_reg <= 16'(TIMEOUT_CYCLES + 4))
    else $error("serial reset at wrong low time");
  a_timeout_release: assert property (smb_if_reset_o |-> !smb_sda_oe_o)
    else $error("data pin driven at serial reset");
  a_clock_free: assert property (!smb_scl_oe_o && !smb_sda_o)
    else $error("clock pin driven or data high");
endmodule
bind tlal_top tlal_props #(.CONV_CYCLES(CONV_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
  .clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_start_o,
  .pwm_oe_o, .alert_oe_o, .tcrit_oe_o, .smb_scl_i, .smb_sda_i, .smb_sda_o, .smb_sda_oe_o,
  .smb_scl_oe_o, .smb_if_reset_o);

/* File: verif/tlal_host_model.sv */
`timescale 1ns/1ns
// host side of the serial pins and the alert line, all pulled up
module tlal_host_model (
  input wire logic clk_i,
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  input wire logic alert_oe_i,
  output logic scl_o,
  output logic sda_o,
  output logic alert_n_o
);
  logic hold_scl = 1'b0; // host keeps the clock low
  // wired levels: low while any party pulls
  assign scl_o = ~(hold_scl | scl_oe_i);
  assign sda_o = ~sda_oe_i;
  assign alert_n_o = ~alert_oe_i;
  // stall the clock low for n cycles, short of or past the timeout
  task automatic hold_low(input int n);
    @(posedge clk_i);
    hold_scl <= 1'b1;
    repeat (n) @(posedge clk_i);
    hold_scl <= 1'b0;
  endtask
endmodule

/* File: verif/tb_temp_limit_alert_logic.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
`define RCK(a, e, nm) begin bus(1'b0, a, 32'h0000_0000); `CHK(nm, e, rdq) end
module tb_temp_limit_alert_logic;
  import tlal_pkg::*;
  localparam int CV = 50; // short conversion
  localparam int TO = 40; // short serial timeout
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pwm_low = 1'b0, drive = 1'b0;
  logic [7:0] adr = 8'h00, loc = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rdq, wb_dat;
  logic [10:0] rem = 11'h000;
  logic ack, conv, pwm_oe, alert_oe, tcrit_oe, scl, sda, sda_o, sda_oe, scl_oe, ifrst, irq, alert_n;
  int err_count = 0, checks = 0, cycles = 0, pulses = 0, n;
  always #25 clk_i = ~clk_i;
  // hang guard and serial reset pulse tally
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    pulses <= pulses + int'(ifrst);
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  tlal_top #(.CONV_CYCLES(CV), .TIMEOUT_CYCLES(TO)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat),
    .wb_ack_o(ack), .local_sample_i(loc), .remote_sample_i(rem), .diode_open_i(1'b0),
    .conv_start_o(conv), .pwm_low_i(pwm_low), .pwm_oe_o(pwm_oe), .alert_oe_o(alert_oe),
    .tcrit_oe_o(tcrit_oe), .smb_scl_i(scl), .smb_sda_i(sda), .smb_sda_drive_i(drive),
    .smb_sda_o(sda_o), .smb_sda_oe_o(sda_oe), .smb_scl_oe_o(scl_oe), .smb_if_reset_o(ifrst), .irq_o(irq));
  tlal_host_model host (.clk_i(clk_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .alert_oe_i(alert_oe),
    .scl_o(scl), .sda_o(sda), .alert_n_o(alert_n));
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rdq = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) err_count++;
  endtask
  // wait for a start pulse, bounded
  task automatic to_start;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (conv !== 1'b1 && k < 400);
  endtask
  // let one whole conversion land after new samples
  task automatic wait_conv;
    to_start();
    repeat (CV + 3) @(posedge clk_i);
  endtask
  task automatic stop_test;
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // limits after reset, plus a hole in the map
    `RCK(ADR_LOC_UPPER, 32'(LOC_UPPER_RST), "loc_up")
    `RCK(ADR_REM_UPPER, 32'(REM_UPPER_RST), "rem_up")
    `RCK(ADR_REM_CRIT, 32'(REM_CRIT_RST), "rem_crit")
    `RCK(ADR_HYST, 32'(HYST_RST), "hyst")
    `RCK(8'h3C, 32'h0000_0000, "hole")
    bus(1'b1, ADR_REM_LOWER, 32'h0000_FFFF);
    `RCK(ADR_REM_LOWER, 32'h0000_FFE0, "rem_low")
    // readings with offset, local over its limit
    bus(1'b1, ADR_REM_OFFSET, 32'h0000_0100);
    loc <= 8'h50;
    rem <= 11'h0C8;
    wait_conv();
    `RCK(ADR_LOC_READ, 32'h0000_0050, "loc_rd")
    `RCK(ADR_REM_READ, 32'({11'h0C8, 5'h00} + 16'h0100), "rem_rd")
    `CHK("alert", 1'b0, alert_n)
    bus(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK("status", 32'h0000_0001, rdq & 32'h0000_000F)
    `CHK("alert_rd", 1'b1, alert_n)
    `RCK(ADR_CTRL, 32'h0000_0004, "ctrl_mask")
    bus(1'b1, ADR_CTRL, 32'h0000_0000);
    wait_conv();
    `CHK("alert_again", 1'b0, alert_n)
    bus(1'b1, ADR_CTRL, 32'h0000_0004);
    `CHK("alert_mask", 1'b1, alert_n)
    bus(1'b1, ADR_CTRL, 32'h0000_0000);
    // remote beyond critical, then back: pin not latched
    rem <= 11'h36F;
    wait_conv();
    `CHK("tcrit", 1'b1, tcrit_oe)
    bus(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK("status2", 32'h0000_000D, rdq & 32'h0000_000F)
    rem <= 11'h0C8;
    wait_conv();
    `CHK("tcrit_off", 1'b0, tcrit_oe)
    // comparator mode: held inside the band, freed below it
    bus(1'b1, ADR_CTRL, 32'h0000_0008);
    loc <= 8'h40;
    wait_conv();
    `CHK("hyst_hold", 1'b0, alert_n)
    loc <= 8'h3B;
    wait_conv();
    `CHK("cmp_free", 1'b1, alert_n)
    bus(1'b1, ADR_CTRL, 32'h0000_0000);
    // start spacing for rates 0 and 1
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, ADR_RATE, 32'(r));
      to_start();
      to_start();
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (conv !== 1'b1 && n < 400);
      `CHK("period", CV * (r + 1), n)
    end
    // standby, pwm stopped then allowed
    pwm_low <= 1'b1;
    bus(1'b1, ADR_CTRL, 32'h0000_0003);
    repeat (3 * CV) @(posedge clk_i);
    n = 0;
    repeat (3 * CV) begin
      @(posedge clk_i);
      n += int'(conv);
    end
    `CHK("standby", 0, n)
    `CHK("pwm_off", 1'b0, pwm_oe)
    bus(1'b1, ADR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    `CHK("pwm_on", 1'b1, pwm_oe)
    // serial low: short stall ignored, long low resets the port
    bus(1'b1, ADR_IRQ_MASK, 32'h0000_0004);
    n = pulses;
    host.hold_low(TO - 10);
    repeat (5) @(posedge clk_i);
    `CHK("short_low", n, pulses)
    drive <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ifrst !== 1'b1 && n < 80);
    `CHK("to_span", 1'b1, n >= TO && n <= TO + 8)
    `CHK("sda_free", 1'b0, sda_oe)
    drive <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("irq_to", 1'b1, irq)
    bus(1'b1, ADR_IRQ_STATUS, 32'h0000_0004);
    repeat (3) @(posedge clk_i);
    `CHK("irq_clr", 1'b0, irq)
    stop_test();
  end
endmodule
